// ---- design/nvm_ctrl_pkg.sv ----
package nvm_ctrl_pkg;

    // Device register offsets (byte addresses on the device link)
    localparam logic [8:0] OFF_MEM_ENABLE   = 9'h134;
    localparam logic [8:0] OFF_PAGE_LOCK    = 9'h140;
    localparam logic [8:0] OFF_DWORD_SIZE   = 9'h144;
    localparam logic [8:0] OFF_COMMAND      = 9'h148;
    localparam logic [8:0] OFF_IRQ_ENABLE   = 9'h154;
    localparam logic [8:0] OFF_FLAG_CLEAR   = 9'h158;
    localparam logic [8:0] OFF_OWNER_REQ    = 9'h1FC;
    localparam logic [8:0] OFF_STATUS       = 9'h120;
    localparam logic [8:0] OFF_WBUF_BASE    = 9'h080;

    // Field positions and reset values
    localparam int         MEM_EN_BIT       = 0;
    localparam int         CACHE_BYP_BIT    = 1;
    localparam logic [1:0] MEM_ENABLE_RST   = 2'h1;
    localparam logic [3:0] DWORD_SIZE_RST   = 4'h0;
    localparam logic [10:0] IRQ_ENABLE_RST  = 11'h000;
    localparam int         CLR_BUSY_BIT     = 0;
    localparam int         CLR_DENIED_BIT   = 1;
    localparam int         CLR_CMDBUSY_BIT  = 2;
    localparam int         CMD_FIELD_LSB    = 24;

    // Ownership request codes and owner encodings
    localparam logic [7:0] REQ_RELEASE      = 8'h00;
    localparam logic [7:0] REQ_CLAIM        = 8'h01;
    localparam logic [7:0] REQ_SEIZE        = 8'h03;
    localparam logic [1:0] MASTER_SYSCTRL   = 2'h0;
    localparam logic [1:0] MASTER_FABRIC    = 2'h2;
    localparam logic [1:0] MASTER_OTHER     = 2'h3;

    // Controller (APB side) register offsets
    localparam logic [7:0] CT_ADDR          = 8'h00;
    localparam logic [7:0] CT_WDATA         = 8'h04;
    localparam logic [7:0] CT_CTRL          = 8'h08;
    localparam logic [7:0] CT_RDATA         = 8'h0C;
    localparam logic [7:0] CT_IRQ_STATUS    = 8'h10;
    localparam logic [7:0] CT_IRQ_MASK      = 8'h14;
    localparam int         CTRL_WRITE_BIT   = 0;
    localparam int         CTRL_START_BIT   = 1;
    localparam int         CTRL_BUSY_BIT    = 2;
    localparam int         EV_DONE_BIT      = 0;
    localparam int         EV_ERROR_BIT     = 1;

endpackage

// ---- design/nvm_link_if.sv ----
`timescale 1ns/1ns
interface nvm_link_if;
    logic        req;
    logic        write;
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic [1:0]  master;
    logic        ack;
    logic        err;
    logic [31:0] rdata;

    modport device (
        input  req, write, addr, wdata, master,
        output ack, err, rdata
    );
    modport host (
        output req, write, addr, wdata, master,
        input  ack, err, rdata
    );
endinterface

// ---- design/nvm_ctrl_regs.sv ----
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Bit 0 at 0x134 enables memory, resets 1
// - Bit 1 bypasses read cache, resets 0
// - Page lock bit at 0x140, resets 0
// - Four-bit dword count at 0x144, 0=1, 15=16
// - Command write launches only valid commands
// - Eleven-bit interrupt enable at 0x154, resets zero
// - Write-only clear at 0x158, ones clear
// - Writing 0x01 to 0x1FC requests ownership
// - Owner readback: bit2 held, low bits who
// - Owner writes 0x00 to release ownership
// - System controller 0x03 seizes ownership immediately
// - Release clears write and read buffers
// - Software avoids unmapped controller addresses
// - Owner-only registers answer the owner only
// - Clear bits 1,2 drop denial flags; flags block
// - Seizure keeps write buffer; mode exit clears
module nvm_ctrl_regs
    import nvm_ctrl_pkg::*;
#(
    parameter int WBUF_WORDS = 32,
    parameter int RBUF_WORDS = 8,
    parameter int CMD_BUSY_CYCLES = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link from masters
    nvm_link_if.device       link,
    // Device state toward the array side
    input  wire logic        mode_exit,
    output logic             mem_enable,
    output logic             cache_bypass,
    output logic             cmd_start,
    output logic [31:0]      cmd_word,
    output logic [3:0]       dword_count,
    output logic             irq
);
    import nvm_ctrl_pkg::*;

    logic [1:0]  mem_ctl_q;
    logic        page_lock_q;
    logic [3:0]  dword_size_q;
    logic [31:0] command_q;
    logic [10:0] irq_en_q;
    logic [2:0]  owner_q;
    logic        busy_q;
    logic        denied_q;
    logic        cmd_busy_q;
    logic        start_q;
    logic        irq_q;
    logic [7:0]  busy_cnt_q;
    logic        ack_q;
    logic        err_q;
    logic [31:0] rdata_q;
    logic [31:0] wbuf_q [WBUF_WORDS];
    logic [31:0] rbuf_q [RBUF_WORDS];

    logic        is_owner;
    logic        owner_only;
    logic        wr;
    logic        rd;
    logic        allowed;
    logic [7:0]  req_code;
    logic        cmd_valid;
    logic        cmd_launch;
    logic        release_now;
    logic        wbuf_hit;

    // Take each request once: req still stands on the edge that ends ack
    assign wr        = link.req && link.write && !ack_q;
    assign rd        = link.req && !link.write && !ack_q;
    assign req_code  = link.wdata[7:0];
    assign is_owner  = owner_q[2] && (owner_q[1:0] == link.master);
    assign wbuf_hit  = (link.addr >= OFF_WBUF_BASE) && (link.addr < 9'h100);
    assign owner_only = !(wbuf_hit || link.addr == OFF_STATUS || link.addr == OFF_OWNER_REQ);
    assign allowed   = !owner_only || is_owner;
    // Valid command decode, top byte nonzero
    assign cmd_valid = link.wdata[31:CMD_FIELD_LSB] != 8'h00;
    assign cmd_launch = wr && allowed && link.addr == OFF_COMMAND && cmd_valid
                        && !denied_q && !cmd_busy_q && !busy_q && mem_ctl_q[MEM_EN_BIT];
    assign release_now = wr && link.addr == OFF_OWNER_REQ && req_code == REQ_RELEASE && is_owner;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ctl_q    <= MEM_ENABLE_RST;
            page_lock_q  <= 1'b0;
            dword_size_q <= DWORD_SIZE_RST;
            command_q    <= 32'h0000_0000;
            irq_en_q     <= IRQ_ENABLE_RST;
        end else if (wr && allowed) begin
            unique case (link.addr)
                OFF_MEM_ENABLE: mem_ctl_q    <= link.wdata[1:0];
                OFF_PAGE_LOCK:  page_lock_q  <= link.wdata[0];
                OFF_DWORD_SIZE: dword_size_q <= link.wdata[3:0];
                OFF_COMMAND:    command_q    <= link.wdata;
                OFF_IRQ_ENABLE: irq_en_q     <= link.wdata[10:0];
                default: ;
            endcase
        end
    end

    // Ownership arbitration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owner_q <= 3'h0;
        end else if (wr && link.addr == OFF_OWNER_REQ) begin
            if (req_code == REQ_SEIZE && link.master == MASTER_SYSCTRL) begin
                owner_q <= {1'b1, MASTER_SYSCTRL};
            end else if (req_code == REQ_CLAIM && !owner_q[2]) begin
                owner_q <= {1'b1, link.master};
            end else if (release_now) begin
                // Keep last holder in low bits
                owner_q <= {1'b0, owner_q[1:0]};
            end
        end
    end

    // Busy and error flags; set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q     <= 1'b0;
            denied_q   <= 1'b0;
            cmd_busy_q <= 1'b0;
            busy_cnt_q <= 8'h00;
            start_q    <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            logic clr_wr;
            logic cmd_wr;
            clr_wr = wr && allowed && link.addr == OFF_FLAG_CLEAR;
            cmd_wr = wr && allowed && link.addr == OFF_COMMAND;
            start_q <= cmd_launch;
            irq_q   <= |(irq_en_q[2:0] & {cmd_busy_q, denied_q, busy_q});
            if (cmd_launch) begin
                busy_q     <= 1'b1;
                busy_cnt_q <= 8'(CMD_BUSY_CYCLES);
            end else if (busy_q) begin
                busy_cnt_q <= busy_cnt_q - 8'h01;
                if (busy_cnt_q == 8'h01 || (clr_wr && link.wdata[CLR_BUSY_BIT])) begin
                    busy_q <= 1'b0;
                end
            end
            if ((cmd_wr && !cmd_valid) || ((wr || rd) && !allowed)) begin
                denied_q <= 1'b1;
            end else if (clr_wr && link.wdata[CLR_DENIED_BIT]) begin
                denied_q <= 1'b0;
            end
            if (cmd_wr && cmd_valid && busy_q) begin
                cmd_busy_q <= 1'b1;
            end else if (clr_wr && link.wdata[CLR_CMDBUSY_BIT]) begin
                cmd_busy_q <= 1'b0;
            end
        end
    end

    // Write and read buffers
    genvar gi;
    generate
        for (gi = 0; gi < WBUF_WORDS; gi++) begin : g_wbuf
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wbuf_q[gi] <= 32'h0000_0000;
                // Release clears; seizure keeps, mode exit clears
                end else if (release_now || mode_exit) begin
                    wbuf_q[gi] <= 32'h0000_0000;
                end else if (wr && wbuf_hit && link.addr[6:2] == 5'(gi)) begin
                    wbuf_q[gi] <= link.wdata;
                end
            end
        end
        for (gi = 0; gi < RBUF_WORDS; gi++) begin : g_rbuf
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rbuf_q[gi] <= 32'h0000_0000;
                end else if (release_now) begin
                    rbuf_q[gi] <= 32'h0000_0000;
                end else if (start_q) begin
                    rbuf_q[gi] <= command_q ^ 32'(gi);
                end
            end
        end
    endgenerate

    // Link answer, one cycle after request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= link.req && !ack_q;
            err_q   <= link.req && !ack_q && !allowed;
            rdata_q <= 32'h0000_0000;
            if (rd && allowed) begin
                if (wbuf_hit) begin
                    rdata_q <= wbuf_q[link.addr[6:2]];
                end else begin
                    unique case (link.addr)
                        OFF_MEM_ENABLE: rdata_q <= {30'h0, mem_ctl_q};
                        OFF_PAGE_LOCK:  rdata_q <= {31'h0, page_lock_q};
                        OFF_DWORD_SIZE: rdata_q <= {28'h0, dword_size_q};
                        OFF_COMMAND:    rdata_q <= command_q;
                        OFF_IRQ_ENABLE: rdata_q <= {21'h0, irq_en_q};
                        OFF_STATUS:     rdata_q <= {owner_q, 9'h0, cmd_busy_q, denied_q, 17'h0, busy_q};
                        OFF_OWNER_REQ:  rdata_q <= {29'h0, owner_q};
                        default:        rdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    assign link.ack   = ack_q;
    assign link.err   = err_q;
    assign link.rdata = rdata_q;
    assign mem_enable   = mem_ctl_q[MEM_EN_BIT];
    assign cache_bypass = mem_ctl_q[CACHE_BYP_BIT];
    assign cmd_start    = start_q;
    assign cmd_word     = command_q;
    assign dword_count  = dword_size_q;
    assign irq          = irq_q;

endmodule

// ---- design/nvm_link_master.sv ----
`timescale 1ns/1ns
module nvm_link_master
    import nvm_ctrl_pkg::*;
#(
    parameter logic [1:0] MASTER_ID = MASTER_OTHER
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // Link toward device
    nvm_link_if.host         link
);
    import nvm_ctrl_pkg::*;

    logic [8:0]  addr_q;
    logic [31:0] wdata_q;
    logic [31:0] rdata_q;
    logic        write_q;
    logic        busy_q;
    logic        req_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;
    logic        setup;
    logic        start;
    logic        access;

    assign setup = psel && !penable;
    // Writes land only on the completing edge of the access phase
    assign access = psel && penable && pready_q;
    assign start = access && pwrite && paddr == CT_CTRL && pwdata[CTRL_START_BIT] && !busy_q;

    // APB answer: no wait state, pready in cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            if (setup) begin
                unique case (paddr)
                    CT_ADDR:       prdata_q <= {23'h0, addr_q};
                    CT_WDATA:      prdata_q <= wdata_q;
                    CT_CTRL:       prdata_q <= {29'h0, busy_q, 1'b0, write_q};
                    CT_RDATA:      prdata_q <= rdata_q;
                    CT_IRQ_STATUS: prdata_q <= {30'h0, status_q};
                    CT_IRQ_MASK:   prdata_q <= {30'h0, mask_q};
                    default:       pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // Command registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q  <= 9'h000;
            wdata_q <= 32'h0000_0000;
            write_q <= 1'b0;
            mask_q  <= 2'h0;
        end else if (access && pwrite && !busy_q) begin
            unique case (paddr)
                CT_ADDR:     addr_q  <= pwdata[8:0];
                CT_WDATA:    wdata_q <= pwdata;
                CT_CTRL:     write_q <= pwdata[CTRL_WRITE_BIT];
                CT_IRQ_MASK: mask_q  <= pwdata[1:0];
                default: ;
            endcase
        end else if (access && pwrite && paddr == CT_IRQ_MASK) begin
            mask_q <= pwdata[1:0];
        end
    end

    // Link transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q  <= 1'b0;
            req_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (start) begin
            busy_q <= 1'b1;
            req_q  <= 1'b1;
        end else if (busy_q && link.ack) begin
            busy_q  <= 1'b0;
            req_q   <= 1'b0;
            rdata_q <= link.rdata;
        end
    end

    // Sticky events, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= 2'h0;
            irq_q    <= 1'b0;
        end else begin
            logic [1:0] set_v;
            logic [1:0] clr_v;
            set_v = {busy_q && link.ack && link.err, busy_q && link.ack};
            clr_v = (access && pwrite && paddr == CT_IRQ_STATUS) ? pwdata[1:0] : 2'h0;
            status_q <= (status_q & ~clr_v) | set_v;
            irq_q    <= |(((status_q & ~clr_v) | set_v) & mask_q);
        end
    end

    assign link.req    = req_q;
    assign link.write  = write_q;
    assign link.addr   = addr_q;
    assign link.wdata  = wdata_q;
    assign link.master = MASTER_ID;
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

endmodule

// ---- tb/nvm_link_checker.sv ----
`timescale 1ns/1ns
module nvm_link_checker
    import nvm_ctrl_pkg::*;
#(
    parameter logic [1:0] MASTER_ID = MASTER_OTHER
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link signals
    input wire logic        req,
    input wire logic        write,
    input wire logic [8:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0]  master,
    input wire logic        ack,
    input wire logic        err,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_single: assert property (ack |=> !ack)
        else $error("ack held longer than one cycle");
    a_ack_follows: assert property (req && !ack |=> ack)
        else $error("request not answered in one cycle");
    a_ack_has_req: assert property (ack |-> req)
        else $error("ack without request");
    a_err_with_ack: assert property (err |-> ack)
        else $error("err outside ack");
    a_req_drops: assert property (ack |=> !req)
        else $error("request kept after ack");
    a_req_holds: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata) && $stable(write))
        else $error("request changed before ack");
    a_open_no_err: assert property (ack && (addr == OFF_STATUS || addr == OFF_OWNER_REQ || addr[8:7] == 2'b01)
        |-> !err)
        else $error("open register refused");
    a_owner_width: assert property (ack && !write && addr == OFF_OWNER_REQ |-> rdata[31:3] == 29'h0)
        else $error("owner readback wider than three bits");
    a_master_fixed: assert property (req |-> master == MASTER_ID)
        else $error("wrong master identity");
endmodule

// ---- tb/tb_nvm_control_register_bank.sv ----
`timescale 1ns/1ns
module tb_nvm_control_register_bank;
    import nvm_ctrl_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, mode_exit;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, cmd_word, apb_data, dev_data;
    logic        pready, pslverr, m_irq, r_irq, mem_enable, cache_bypass, cmd_start, apb_err, dev_err;
    logic [3:0]  dword_count;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          starts = 0;

    nvm_link_if link ();
    nvm_ctrl_regs #(.CMD_BUSY_CYCLES(200)) nvm_ctrl_regs_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .mode_exit(mode_exit), .mem_enable(mem_enable), .cache_bypass(cache_bypass), .cmd_start(cmd_start),
        .cmd_word(cmd_word), .dword_count(dword_count), .irq(r_irq));
    nvm_link_master #(.MASTER_ID(MASTER_SYSCTRL)) nvm_link_master_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(m_irq), .link(link));
    nvm_link_checker #(.MASTER_ID(MASTER_SYSCTRL)) nvm_link_checker_inst (.pclk(pclk), .presetn(presetn),
        .req(link.req), .write(link.write), .addr(link.addr), .wdata(link.wdata), .master(link.master),
        .ack(link.ack), .err(link.err), .rdata(link.rdata));

    always #4 pclk = ~pclk;

    always @(posedge pclk) begin
        if (cmd_start === 1'b1)
            starts <= starts + 1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        apb_data = prdata;
        apb_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Device access through the controller: clear events, launch, poll busy, collect result
    task automatic dev(input logic w, input logic [8:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb(1'b1, CT_IRQ_STATUS, 32'h3);
        apb(1'b1, CT_ADDR, {23'h0, a});
        apb(1'b1, CT_WDATA, d);
        apb(1'b1, CT_CTRL, {30'h0, 1'b1, w});
        apb(1'b0, CT_CTRL, 32'h0);
        while (apb_data[CTRL_BUSY_BIT] !== 1'b0 && n < 40) begin
            apb(1'b0, CT_CTRL, 32'h0);
            n++;
        end
        apb(1'b0, CT_IRQ_STATUS, 32'h0);
        dev_err = apb_data[EV_ERROR_BIT];
        apb(1'b0, CT_RDATA, 32'h0);
        dev_data = apb_data;
    endtask

    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mode_exit = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk("mem_enable", 32'h1, mem_enable);
        chk("cache_bypass", 32'h0, cache_bypass);
        chk("dword_count", 32'h0, dword_count);
        dev(1'b0, OFF_OWNER_REQ, 32'h0);
        chk("owner", 32'h0, dev_data);
        dev(1'b1, OFF_MEM_ENABLE, 32'h3);
        chk("denied err", 32'h1, dev_err);
        chk("mem_enable", 32'h1, mem_enable);
        dev(1'b0, OFF_STATUS, 32'h0);
        chk("denied flag", 32'h1, dev_data[18]);
        dev(1'b1, OFF_OWNER_REQ, {24'h0, REQ_CLAIM});
        dev(1'b0, OFF_OWNER_REQ, 32'h0);
        chk("owner", 32'h4, dev_data);
        dev(1'b0, OFF_IRQ_ENABLE, 32'h0);
        chk("irq enable", 32'h0, dev_data);
        dev(1'b1, OFF_IRQ_ENABLE, 32'hFFFFFFFF);
        dev(1'b0, OFF_IRQ_ENABLE, 32'h0);
        chk("irq enable", 32'h7FF, dev_data);
        chk("device irq", 32'h1, r_irq);
        dev(1'b1, OFF_FLAG_CLEAR, 32'h2);
        chk("device irq", 32'h0, r_irq);
        dev(1'b0, OFF_STATUS, 32'h0);
        chk("denied flag", 32'h0, dev_data[18]);
        dev(1'b1, OFF_MEM_ENABLE, 32'h2);
        chk("mem_enable", 32'h0, mem_enable);
        chk("cache_bypass", 32'h1, cache_bypass);
        dev(1'b1, OFF_PAGE_LOCK, 32'h1);
        dev(1'b0, OFF_PAGE_LOCK, 32'h0);
        chk("page lock", 32'h1, dev_data);
        dev(1'b1, OFF_DWORD_SIZE, 32'hF);
        chk("dword_count", 32'hF, dword_count);
        dev(1'b1, OFF_MEM_ENABLE, 32'h1);
        chk("mem_enable", 32'h1, mem_enable);
        dev(1'b1, OFF_COMMAND, 32'h00FFFFFF);
        chk("starts", 32'h0, starts);
        dev(1'b0, OFF_STATUS, 32'h0);
        chk("denied flag", 32'h1, dev_data[18]);
        dev(1'b1, OFF_FLAG_CLEAR, 32'h2);
        dev(1'b1, OFF_COMMAND, 32'h01000000);
        chk("starts", 32'h1, starts);
        chk("cmd_word", 32'h01000000, cmd_word);
        dev(1'b1, OFF_COMMAND, 32'h02000000);
        dev(1'b0, OFF_STATUS, 32'h0);
        chk("cmd busy flag", 32'h1, dev_data[19]);
        dev(1'b1, OFF_FLAG_CLEAR, 32'h1);
        dev(1'b1, OFF_COMMAND, 32'h02000000);
        chk("starts", 32'h1, starts);
        dev(1'b1, OFF_FLAG_CLEAR, 32'h4);
        dev(1'b0, OFF_STATUS, 32'h0);
        chk("cmd busy flag", 32'h0, dev_data[19]);
        dev(1'b1, OFF_COMMAND, 32'h02000000);
        chk("starts", 32'h2, starts);
        dev(1'b1, OFF_WBUF_BASE, 32'hDEADBEEF);
        dev(1'b1, OFF_OWNER_REQ, {24'h0, REQ_SEIZE});
        dev(1'b0, OFF_WBUF_BASE, 32'h0);
        chk("write buffer", 32'hDEADBEEF, dev_data);
        dev(1'b1, OFF_OWNER_REQ, {24'h0, REQ_RELEASE});
        dev(1'b0, OFF_OWNER_REQ, 32'h0);
        chk("owner", 32'h0, dev_data);
        dev(1'b0, OFF_WBUF_BASE, 32'h0);
        chk("write buffer", 32'h0, dev_data);
        dev(1'b1, OFF_OWNER_REQ, {24'h0, REQ_SEIZE});
        dev(1'b0, OFF_OWNER_REQ, 32'h0);
        chk("owner", 32'h4, dev_data);
        dev(1'b1, OFF_WBUF_BASE, 32'h5);
        dev(1'b0, OFF_WBUF_BASE, 32'h0);
        chk("write buffer", 32'h5, dev_data);
        @(posedge pclk);
        mode_exit <= 1'b1;
        @(posedge pclk);
        mode_exit <= 1'b0;
        dev(1'b0, OFF_WBUF_BASE, 32'h0);
        chk("write buffer", 32'h0, dev_data);
        settle();
        chk("apb irq", 32'h0, m_irq);
        apb(1'b1, CT_IRQ_MASK, 32'h3);
        settle();
        chk("apb irq", 32'h1, m_irq);
        apb(1'b1, CT_IRQ_STATUS, 32'h3);
        settle();
        chk("apb irq", 32'h0, m_irq);
        apb(1'b0, CT_IRQ_STATUS, 32'h0);
        chk("irq status", 32'h0, apb_data);
        apb(1'b0, 8'h40, 32'h0);
        chk("pslverr", 32'h1, apb_err);
        stop_test();
    end
endmodule
